// *** hdl/picture_adjust_pkg.sv ***
// Register map, field widths and arithmetic constants of the picture regs.
package picture_adjust_pkg;

   // Register indices; the APB byte address is four times the index.
   localparam logic [7:0] IDX_VOFS_LO = 8'h22;
   localparam logic [7:0] IDX_VOFS_HI = 8'h23;
   localparam logic [7:0] IDX_HSCL_LO = 8'h24;
   localparam logic [7:0] IDX_HSCL_HI = 8'h25;
   localparam logic [7:0] IDX_GAIN_LO = 8'h26;
   localparam logic [7:0] IDX_GAIN_HI = 8'h27;
   localparam logic [7:0] IDX_BOFS_LO = 8'h28;
   localparam logic [7:0] IDX_BOFS_HI = 8'h29;
   localparam logic [7:0] IDX_PEAK_LO = 8'h2A;
   localparam logic [7:0] IDX_PEAK_HI = 8'h2B;
   localparam logic [7:0] IDX_VFILT_LO = 8'h2C;
   localparam logic [7:0] IDX_VFILT_HI = 8'h2D;
   localparam int ADDR_SHIFT = 2;

   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam int BYTE_W = 8;
   localparam int PIX_W = 8;

   // Field widths.
   localparam int VOFS_W = 10;
   localparam int HSCL_W = 9;
   localparam int GAIN_W = 6;
   localparam int BOFS_W = 8;
   localparam int PEAK_W = 5;
   localparam int VFILT_W = 5;
   localparam int PHASE_W = 10;

   // Reset values.
   localparam logic [VOFS_W-1:0] VOFS_RST = 10'h000;
   localparam logic [HSCL_W-1:0] HSCL_RST = 9'h000;
   localparam logic [GAIN_W-1:0] GAIN_RST = 6'h20;
   localparam logic [BOFS_W-1:0] BOFS_RST = 8'h00;
   localparam logic [PEAK_W-1:0] PEAK_RST = 5'h10;
   localparam logic [VFILT_W-1:0] VFILT_RST = 5'h00;

   // Implied denominators as shift counts and unity terms.
   localparam int HSCL_DEN_SH = 7;
   localparam int GAIN_DEN_SH = 5;
   localparam int PEAK_DEN_SH = 4;
   localparam int VFILT_DEN_SH = 6;
   localparam logic [5:0] VFILT_CUR_UNITY = 6'h20;
   localparam logic [PHASE_W-1:0] HSCL_UNITY = 10'h080;
   localparam logic [7:0] PIX_MAX = 8'hFF;

endpackage

// *** hdl/output_picture_adjust_regs.sv ***
// Output picture adjust registers with APB slave and luma/scan datapath.
`timescale 1ns/1ps
module output_picture_adjust_regs
   import picture_adjust_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [APB_AW-1:0] PADDR_I,
   input wire logic [APB_DW-1:0] PWDATA_I,
   output logic [APB_DW-1:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic FIELD_START_I,
   input wire logic LINE_START_I,
   output logic ACTIVE_START_O,
   output logic ACTIVE_LINE_O,
   output logic [VOFS_W-1:0] LINE_COUNT_O,
   input wire logic PIX_VALID_I,
   input wire logic [PIX_W-1:0] LINE_ABOVE_I,
   input wire logic [PIX_W-1:0] LINE_CUR_I,
   input wire logic [PIX_W-1:0] LINE_BELOW_I,
   output logic PIX_VALID_O,
   output logic [PIX_W-1:0] LUMA_O,
   input wire logic HSCALE_IN_I,
   output logic HSCALE_READY_O,
   output logic HSCALE_EMIT_O
);

   // Byte address of a register index.
   function automatic logic [APB_AW-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = APB_AW'({idx, 2'b00});
   endfunction

   // Saturates a signed intermediate to the pixel range.
   function automatic logic [PIX_W-1:0] clamp_pixel(
      input logic signed [16:0] v);
      if (v < 17'sd0) begin
         clamp_pixel = '0;
      end else if (v > $signed({9'h000, PIX_MAX})) begin
         clamp_pixel = PIX_MAX;
      end else begin
         clamp_pixel = v[PIX_W-1:0];
      end
   endfunction

   logic [VOFS_W-1:0] output_vertical_offset;
   logic [HSCL_W-1:0] horiz_scale_coeff;
   logic [GAIN_W-1:0] contrast_gain;
   logic [BOFS_W-1:0] brightness_offset;
   logic [PEAK_W-1:0] peaking_gain;
   logic [VFILT_W-1:0] vertical_filter_coeff;

   // APB decode.
   wire setup_phase = PSEL_I && !PENABLE_I;
   wire access_phase = PSEL_I && PENABLE_I;
   wire wr_en = access_phase && PWRITE_I;
   wire [BYTE_W-1:0] wbyte = PWDATA_I[BYTE_W-1:0];
   wire hit_vofs_lo = PADDR_I == reg_addr(IDX_VOFS_LO);
   wire hit_vofs_hi = PADDR_I == reg_addr(IDX_VOFS_HI);
   wire hit_hscl_lo = PADDR_I == reg_addr(IDX_HSCL_LO);
   wire hit_hscl_hi = PADDR_I == reg_addr(IDX_HSCL_HI);
   wire hit_gain_lo = PADDR_I == reg_addr(IDX_GAIN_LO);
   wire hit_gain_hi = PADDR_I == reg_addr(IDX_GAIN_HI);
   wire hit_bofs_lo = PADDR_I == reg_addr(IDX_BOFS_LO);
   wire hit_bofs_hi = PADDR_I == reg_addr(IDX_BOFS_HI);
   wire hit_peak_lo = PADDR_I == reg_addr(IDX_PEAK_LO);
   wire hit_peak_hi = PADDR_I == reg_addr(IDX_PEAK_HI);
   wire hit_vfilt_lo = PADDR_I == reg_addr(IDX_VFILT_LO);
   wire hit_vfilt_hi = PADDR_I == reg_addr(IDX_VFILT_HI);
   // A word outside the map answers with an error and reads zero.
   wire hit_any = hit_vofs_lo || hit_vofs_hi ||
      hit_hscl_lo || hit_hscl_hi ||
      hit_gain_lo || hit_gain_hi ||
      hit_bofs_lo || hit_bofs_hi ||
      hit_peak_lo || hit_peak_hi ||
      hit_vfilt_lo || hit_vfilt_hi;

   logic [BYTE_W-1:0] rd_byte;
   logic rd_err;

   // High bytes without a field and unused upper bits read back as zero.
   always_comb begin
      rd_byte = '0;
      if (hit_vofs_lo) begin
         rd_byte = output_vertical_offset[BYTE_W-1:0];
      end else if (hit_vofs_hi) begin
         rd_byte = BYTE_W'(output_vertical_offset[VOFS_W-1:BYTE_W]);
      end else if (hit_hscl_lo) begin
         rd_byte = horiz_scale_coeff[BYTE_W-1:0];
      end else if (hit_hscl_hi) begin
         rd_byte = BYTE_W'(horiz_scale_coeff[HSCL_W-1:BYTE_W]);
      end else if (hit_gain_lo) begin
         rd_byte = BYTE_W'(contrast_gain);
      end else if (hit_bofs_lo) begin
         rd_byte = brightness_offset;
      end else if (hit_peak_lo) begin
         rd_byte = BYTE_W'(peaking_gain);
      end else if (hit_vfilt_lo) begin
         rd_byte = BYTE_W'(vertical_filter_coeff);
      end
   end

   // Every access completes in its first access cycle.
   assign rd_err = !hit_any;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = access_phase && rd_err;

   // Read data is captured during setup so it stands from a flip-flop.
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PRDATA_O <= '0;
      end else if (setup_phase && !PWRITE_I) begin
         PRDATA_O <= APB_DW'(rd_byte);
      end
   end

   // Per-register write strobes. High bytes without a field have none, so
   // a value written there is dropped.
   wire wr_vofs_lo = wr_en && hit_vofs_lo;
   wire wr_vofs_hi = wr_en && hit_vofs_hi;
   wire wr_hscl_lo = wr_en && hit_hscl_lo;
   wire wr_hscl_hi = wr_en && hit_hscl_hi;
   wire wr_gain_lo = wr_en && hit_gain_lo;
   wire wr_bofs_lo = wr_en && hit_bofs_lo;
   wire wr_peak_lo = wr_en && hit_peak_lo;
   wire wr_vfilt_lo = wr_en && hit_vfilt_lo;

   // The offset halves are written independently, each at its own edge.
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         output_vertical_offset <= VOFS_RST;
      end else if (wr_vofs_lo) begin
         output_vertical_offset[BYTE_W-1:0] <= wbyte;
      end else if (wr_vofs_hi) begin
         output_vertical_offset[VOFS_W-1:BYTE_W] <=
            wbyte[VOFS_W-BYTE_W-1:0];
      end
   end

   // The scale halves are written independently as well.
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         horiz_scale_coeff <= HSCL_RST;
      end else if (wr_hscl_lo) begin
         horiz_scale_coeff[BYTE_W-1:0] <= wbyte;
      end else if (wr_hscl_hi) begin
         horiz_scale_coeff[HSCL_W-1:BYTE_W] <=
            wbyte[HSCL_W-BYTE_W-1:0];
      end
   end

   // Contrast keeps only its six field bits.
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         contrast_gain <= GAIN_RST;
      end else if (wr_gain_lo) begin
         contrast_gain <= wbyte[GAIN_W-1:0];
      end
   end

   // Brightness uses the whole byte as a signed value.
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         brightness_offset <= BOFS_RST;
      end else if (wr_bofs_lo) begin
         brightness_offset <= wbyte;
      end
   end

   // Sharpness keeps only its five field bits.
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         peaking_gain <= PEAK_RST;
      end else if (wr_peak_lo) begin
         peaking_gain <= wbyte[PEAK_W-1:0];
      end
   end

   // The filter coefficient is stored as written, large values included.
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         vertical_filter_coeff <= VFILT_RST;
      end else if (wr_vfilt_lo) begin
         vertical_filter_coeff <= wbyte[VFILT_W-1:0];
      end
   end

   // Output line placement; the field start pulse marks line zero,
   // the first line of the equalization pulses. The count saturates so
   // that a missing field start cannot wrap it back onto the offset.
   logic [VOFS_W-1:0] line_count;
   logic [VOFS_W-1:0] next_line_count;
   wire line_at_max = &line_count;

   always_comb begin
      next_line_count = line_count;
      if (FIELD_START_I) begin
         next_line_count = '0;
      end else if (LINE_START_I && !line_at_max) begin
         next_line_count = line_count + VOFS_W'(1);
      end
   end

   wire line_event = FIELD_START_I || LINE_START_I;
   wire offset_reached = line_event &&
      (next_line_count == output_vertical_offset);

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         line_count <= '0;
         ACTIVE_START_O <= 1'b0;
         ACTIVE_LINE_O <= 1'b0;
      end else begin
         line_count <= next_line_count;
         ACTIVE_START_O <= offset_reached;
         if (offset_reached) begin
            ACTIVE_LINE_O <= 1'b1;
         end else if (FIELD_START_I) begin
            ACTIVE_LINE_O <= 1'b0;
         end
      end
   end

   assign LINE_COUNT_O = line_count;

   // Horizontal scaler timing: each input pixel adds 128 + n to the phase
   // and each output pixel takes 128 back, giving (1 + n/128) outputs per
   // input. The input is held off while output pixels remain owed.
   // The phase never exceeds 127 + 128 + 511, well inside its width.
   logic [PHASE_W-1:0] scale_phase;
   logic [PHASE_W-1:0] next_scale_phase;
   wire phase_owed = scale_phase >= HSCL_UNITY;
   wire scale_take = HSCALE_IN_I && !phase_owed;

   always_comb begin
      next_scale_phase = scale_phase;
      if (phase_owed) begin
         next_scale_phase = scale_phase - HSCL_UNITY;
      end else if (scale_take) begin
         next_scale_phase = scale_phase + HSCL_UNITY +
            PHASE_W'(horiz_scale_coeff);
      end
   end

   assign HSCALE_READY_O = !phase_owed;

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scale_phase <= '0;
         HSCALE_EMIT_O <= 1'b0;
      end else begin
         scale_phase <= next_scale_phase;
         HSCALE_EMIT_O <= phase_owed;
      end
   end

   // Stage 1: three-line flicker filter over 64ths. The centre weight is
   // twice (32 - coeff); large coefficients are used as written.
   // Coefficients up to 31 keep the centre weight at one or more, so the
   // weight never wraps.
   wire [5:0] coeff_ext = 6'(vertical_filter_coeff);
   wire [5:0] cur_weight = VFILT_CUR_UNITY - coeff_ext;
   // The outer taps share one weight, so they are summed first.
   wire [PIX_W:0] outer_sum = (PIX_W+1)'(LINE_ABOVE_I) +
      (PIX_W+1)'(LINE_BELOW_I);
   wire [16:0] filt_num = 17'(outer_sum) * 17'(coeff_ext) +
      ((17'(LINE_CUR_I) * 17'(cur_weight)) << 1);
   wire [16:0] filt_res = filt_num >> VFILT_DEN_SH;

   logic [PIX_W-1:0] filt1;
   logic [PIX_W-1:0] cur1;
   logic valid1;

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         filt1 <= '0;
         cur1 <= '0;
         valid1 <= 1'b0;
      end else begin
         filt1 <= clamp_pixel($signed(filt_res));
         cur1 <= LINE_CUR_I;
         valid1 <= PIX_VALID_I;
      end
   end

   // Stage 2: peaking restores the detail the filter took away, scaled by
   // sharpness over 16, so the filter coefficient sets the impulse shape.
   wire signed [16:0] detail = 17'(cur1) - 17'(filt1);
   wire signed [16:0] peak_prod = detail * $signed(17'(peaking_gain));
   // A negative detail term rounds down through the arithmetic shift.
   wire signed [16:0] peak_term = peak_prod >>> PEAK_DEN_SH;
   wire signed [16:0] sharp_sum = 17'(filt1) + peak_term;

   logic [PIX_W-1:0] sharp2;
   logic valid2;

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sharp2 <= '0;
         valid2 <= 1'b0;
      end else begin
         sharp2 <= clamp_pixel(sharp_sum);
         valid2 <= valid1;
      end
   end

   // Stage 3: luma encoder gain over 32, then the signed offset.
   wire [16:0] gain_prod = 17'(sharp2) * 17'(contrast_gain);
   wire [16:0] gain_res = gain_prod >> GAIN_DEN_SH;
   // The offset is sign extended before the sum so that a negative value
   // darkens the picture; only the final result is clamped.
   wire signed [16:0] bright_ext = 17'($signed(brightness_offset));
   wire signed [16:0] luma_sum = $signed(gain_res) + bright_ext;

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         LUMA_O <= '0;
         PIX_VALID_O <= 1'b0;
      end else begin
         LUMA_O <= clamp_pixel(luma_sum);
         PIX_VALID_O <= valid2;
      end
   end

   // Offset limits per standard are left to software.

endmodule

// *** tb/picture_regs_monitor.sv ***
// Concurrent checks on the ports of the picture adjust register block.
`timescale 1ns/1ps
module picture_regs_monitor
   import picture_adjust_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic [APB_AW-1:0] PADDR_I,
   input wire logic [APB_DW-1:0] PRDATA_O,
   input wire logic PSLVERR_O,
   input wire logic FIELD_START_I,
   input wire logic LINE_START_I,
   input wire logic ACTIVE_START_O,
   input wire logic ACTIVE_LINE_O,
   input wire logic [VOFS_W-1:0] LINE_COUNT_O,
   input wire logic PIX_VALID_I,
   input wire logic PIX_VALID_O,
   input wire logic HSCALE_IN_I,
   input wire logic HSCALE_READY_O,
   input wire logic HSCALE_EMIT_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   a_field_clears_count: assert property (FIELD_START_I |=>
      LINE_COUNT_O == 10'h000) else $error("count not cleared");
   a_line_count_step: assert property (LINE_START_I && !FIELD_START_I
      && LINE_COUNT_O != 10'h3FF |=> LINE_COUNT_O ==
      $past(LINE_COUNT_O) + 10'h001) else $error("count not stepped");
   a_start_sets_line: assert property (ACTIVE_START_O |->
      ACTIVE_LINE_O) else $error("start without active line");
   a_line_rises_start: assert property ($rose(ACTIVE_LINE_O) |->
      ACTIVE_START_O) else $error("active line rose alone");
   a_active_line_holds: assert property (ACTIVE_LINE_O &&
      !FIELD_START_I |=> ACTIVE_LINE_O) else $error("active line fell");
   a_pix_valid_delay: assert property (PIX_VALID_I |-> ##3
      PIX_VALID_O) else $error("pixel valid delay wrong");
   a_rdata_upper_zero: assert property (PRDATA_O[31:8] ==
      24'h00_0000) else $error("read data upper bits set");
   a_unmapped_error: assert property (PSEL_I && PENABLE_I &&
      PADDR_I[1:0] == 2'h0 |-> PSLVERR_O == (PADDR_I < 8'h88 ||
      PADDR_I > 8'hB4)) else $error("error response wrong");
   a_scale_emit: assert property (HSCALE_IN_I && HSCALE_READY_O |=>
      !HSCALE_READY_O ##1 HSCALE_EMIT_O) else $error("no output pixel");
endmodule
bind output_picture_adjust_regs picture_regs_monitor picture_regs_monitor_i (
   .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
   .PSLVERR_O(PSLVERR_O), .FIELD_START_I(FIELD_START_I),
   .LINE_START_I(LINE_START_I), .ACTIVE_START_O(ACTIVE_START_O),
   .ACTIVE_LINE_O(ACTIVE_LINE_O), .LINE_COUNT_O(LINE_COUNT_O),
   .PIX_VALID_I(PIX_VALID_I), .PIX_VALID_O(PIX_VALID_O),
   .HSCALE_IN_I(HSCALE_IN_I), .HSCALE_READY_O(HSCALE_READY_O),
   .HSCALE_EMIT_O(HSCALE_EMIT_O));

// *** tb/tb_output_picture_adjust_regs.sv ***
// Self-checking bench for the output picture adjust registers.
`timescale 1ns/1ps
module tb_output_picture_adjust_regs
   import picture_adjust_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic fld = 1'b0, ls = 1'b0, pv = 1'b0, hin = 1'b0;
   logic [7:0] pa = 8'h00, la = 8'h00, lc = 8'h00, lb = 8'h00, luma;
   logic [31:0] pwd = 32'h0000_0000, prdata;
   logic pready, pslverr, act_start, act_line, pv_o, hrdy, hemit;
   logic [9:0] lcount;
   int num_errors = 0, n_checks = 0, emits = 0;
   logic [7:0] rst_val [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00,
      8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
   logic [7:0] mask [12] = '{8'hFF, 8'h03, 8'hFF, 8'h01, 8'h3F, 8'h00,
      8'hFF, 8'h00, 8'h1F, 8'h00, 8'h1F, 8'h00};
   int cfg [5][4] = '{'{32, 0, 16, 0}, '{33, -1, 16, 16},
      '{63, 127, 31, 24}, '{0, -128, 0, 31}, '{20, 10, 8, 21}};

   output_picture_adjust_regs output_picture_adjust_regs_i (
      .CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .FIELD_START_I(fld),
      .LINE_START_I(ls), .ACTIVE_START_O(act_start),
      .ACTIVE_LINE_O(act_line), .LINE_COUNT_O(lcount),
      .PIX_VALID_I(pv), .LINE_ABOVE_I(la), .LINE_CUR_I(lc),
      .LINE_BELOW_I(lb), .PIX_VALID_O(pv_o), .LUMA_O(luma),
      .HSCALE_IN_I(hin), .HSCALE_READY_O(hrdy), .HSCALE_EMIT_O(hemit));

   always #4 clk = ~clk;
   always @(posedge clk) if (hemit === 1'b1) emits++;

   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, x);
      n_checks++;
      if (s !== x) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, x, s);
      end
   endtask

   task automatic lost(input string nm);
      num_errors++;
      $display("wrong value %s expected done seen timeout", nm);
      conclude();
   endtask

   // One APB transfer; read data and error are taken at the ready edge.
   task automatic acc(input logic w, input logic [7:0] idx,
      input logic [31:0] d, x, input logic ex);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= idx << ADDR_SHIFT;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) lost("pready");
      if (!w) chk("read data", prdata, x);
      chk("slave error", {31'h0, pslverr}, {31'h0, ex});
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   function automatic int cl(int v);
      return v < 0 ? 0 : (v > 255 ? 255 : v);
   endfunction

   function automatic int ref_y(int a, c, b, int i);
      int f;
      int s;
      f = cl((cfg[i][3] * (a + b) + 2 * (32 - cfg[i][3]) * c) >>> 6);
      s = cl(f + (((c - f) * cfg[i][2]) >>> 4));
      return cl(((s * cfg[i][0]) >>> 5) + cfg[i][1]);
   endfunction

   task automatic pix(input int a, c, b, i);
      @(posedge clk);
      pv <= 1'b1;
      la <= a[7:0];
      lc <= c[7:0];
      lb <= b[7:0];
      @(posedge clk);
      pv <= 1'b0;
      repeat (3) @(posedge clk);
      chk("pixel valid", {31'h0, pv_o}, 32'h0000_0001);
      chk("luma", {24'h0, luma}, ref_y(a, c, b, i));
   endtask

   task automatic scale(input logic [8:0] n, input int x);
      int got;
      int k;
      got = 0;
      k = 0;
      acc(1'b1, IDX_HSCL_LO, {24'h0, n[7:0]}, 0, 1'b0);
      acc(1'b1, IDX_HSCL_HI, {31'h0, n[8]}, 0, 1'b0);
      @(posedge clk);
      emits = 0;
      hin <= 1'b1;
      while (got < 4 && k < 100) begin
         @(posedge clk);
         k++;
         if (hin === 1'b1 && hrdy === 1'b1) got++;
         if (got == 4) hin <= 1'b0;
      end
      if (k >= 100) lost("scaler input");
      repeat (40) @(posedge clk);
      chk("output pixels", emits, x);
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      lost("run");
   end

   initial begin
      int k;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         acc(0, 8'h22 + i[7:0], 0, {24'h0, rst_val[i]}, 0);
      end
      for (int i = 0; i < 12; i++) begin
         acc(1, 8'h22 + i[7:0], 32'hFFFF_FFFF, 0, 0);
         acc(0, 8'h22 + i[7:0], 0, {24'h0, mask[i]}, 0);
      end
      acc(1, 8'h21, 32'hFFFF_FFFF, 0, 1);
      acc(0, 8'h21, 0, 0, 1);
      acc(0, 8'h2E, 0, 0, 1);
      $display("test registers done");
      acc(1, IDX_VOFS_LO, 32'h0000_0014, 0, 0);
      acc(1, IDX_VOFS_HI, 0, 0, 0);
      @(posedge clk);
      fld <= 1'b1;
      @(posedge clk);
      fld <= 1'b0;
      ls <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         if (k == 19) ls <= 1'b0;
         k++;
      end while (act_start !== 1'b1 && k < 40);
      if (k >= 40) lost("active start");
      chk("line count", lcount, 20);
      chk("active line", act_line, 1);
      @(posedge clk);
      fld <= 1'b1;
      @(posedge clk);
      fld <= 1'b0;
      repeat (2) @(posedge clk);
      chk("active line", act_line, 0);
      $display("test vertical offset done");
      for (int i = 0; i < 5; i++) begin
         acc(1, IDX_GAIN_LO, cfg[i][0], 0, 0);
         acc(1, IDX_BOFS_LO, cfg[i][1], 0, 0);
         acc(1, IDX_PEAK_LO, cfg[i][2], 0, 0);
         acc(1, IDX_VFILT_LO, cfg[i][3], 0, 0);
         pix(10, 200, 30, i);
         pix(255, 0, 255, i);
         pix(90, 100, 110, i);
      end
      $display("test luma path done");
      scale(9'h000, 4);
      scale(9'h040, 6);
      scale(9'h17F, 15);
      $display("test scaler done");
      conclude();
   end
endmodule
